// File: design/sarc_ctrl.sv
// sarc_ctrl: successive-approximation control, registers and sequencing
// assumes an AHB-Lite master, an oscillator clock enable and an analog comparator
`timescale 1ns/1ps
module sarc_ctrl (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic osc_tick_in,
  input wire logic stop_mode_in,
  input wire logic comp_above_in,
  output sarc_pkg::sarc_analog_t analog_out,
  output logic conv_irq_out
);
  import sarc_pkg::*;

  typedef enum logic [2:0] {
    SARC_IDLE = 3'b001,
    SARC_SAMPLE = 3'b010,
    SARC_DECIDE = 3'b100
  } sarc_state_t;

  sarc_state_t state_r;
  sarc_state_t state_nxt;
  sarc_ctrl_t ctrl_r;
  logic complete_r;
  logic irq_r;
  logic [7:0] result_r;
  logic [7:0] trial_r;
  logic [7:0] trial_nxt;
  logic [7:0] bit_r;
  logic [7:0] bit_nxt;
  logic [4:0] ticks_r;
  logic [4:0] ticks_nxt;
  logic ph_write_r;
  logic [3:0] ph_addr_r;
  logic ph_read_r;
  logic [3:0] ph_raddr;

  // ---------------------------------------------------------------
  // bus address phase decode
  // ---------------------------------------------------------------
  wire addr_valid = hsel_in & hready_in & htrans_in[1];
  wire [3:0] addr_low = haddr_in[3:0];
  wire wr_sc = ph_write_r & (ph_addr_r == SARC_OFS_STATUS_CONTROL);
  wire wr_clk = ph_write_r & (ph_addr_r == SARC_OFS_CLOCK_CONFIG);
  wire rd_result = addr_valid & ~hwrite_in & (addr_low == SARC_OFS_RESULT);

  // latch address phase; write data lands one cycle later
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ph_write_r <= 1'b0;
      ph_read_r <= 1'b0;
      ph_addr_r <= 4'h0;
    end else begin
      ph_write_r <= addr_valid & hwrite_in;
      ph_read_r <= addr_valid & ~hwrite_in;
      ph_addr_r <= addr_low;
    end
  end

  // zero-wait slave, always OKAY; unmapped reads return zero
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign ph_raddr = ph_addr_r;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // the written flag bit is ignored: its write function is reserved
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_r.irq_en <= 1'b0;
      ctrl_r.cont <= 1'b0;
      ctrl_r.chan <= SARC_CHAN_RESET;
      ctrl_r.clk_src <= 1'b0;
      ctrl_r.prescale <= SARC_PRE_RESET;
    end else begin
      if (wr_sc) begin
        ctrl_r.irq_en <= hwdata_in[SARC_BIT_IRQ_EN];
        ctrl_r.cont <= hwdata_in[SARC_BIT_CONT];
        ctrl_r.chan <= hwdata_in[4:0];
      end
      if (wr_clk) begin
        ctrl_r.prescale <= hwdata_in[SARC_PRE_LSB +: 3];
        ctrl_r.clk_src <= hwdata_in[SARC_BIT_CLK_SRC];
      end
    end
  end

  // ---------------------------------------------------------------
  // converter clock: bus clock or oscillator, then prescaler
  // ---------------------------------------------------------------
  wire powered_down = (ctrl_r.chan == SARC_CHAN_OFF);
  wire src_tick = ctrl_r.clk_src ? 1'b1 : osc_tick_in;
  wire running = (state_r != SARC_IDLE);
  wire conv_tick;

  sarc_divider u_div (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .src_tick_in(src_tick),
    .prescale_in(ctrl_r.prescale),
    .run_in(running),
    .tick_out(conv_tick)
  );

  // ---------------------------------------------------------------
  // sequencer: eight sample ticks then eight bit decisions
  // ---------------------------------------------------------------
  // a control write restarts; stale work is discarded on purpose
  // a write judges power state by the new channel, not the one it replaces
  wire wr_off = (hwdata_in[4:0] == SARC_CHAN_OFF);
  wire start = wr_sc & ~wr_off & ~stop_mode_in;
  wire abort = stop_mode_in | (wr_sc ? wr_off : powered_down);
  wire last_decide = (state_r == SARC_DECIDE) & conv_tick & bit_r[0];
  wire done = last_decide & ~abort & ~wr_sc;
  wire [7:0] final_word = comp_above_in ? trial_r : (trial_r & ~bit_r);

  always_comb begin
    state_nxt = state_r;
    trial_nxt = trial_r;
    bit_nxt = bit_r;
    ticks_nxt = ticks_r;
    if (abort) begin
      state_nxt = SARC_IDLE;
    end else if (start) begin
      state_nxt = SARC_SAMPLE;
      ticks_nxt = 5'h00;
      bit_nxt = 8'h80;
      trial_nxt = 8'h80;
    end else begin
      unique case (state_r)
        SARC_IDLE: begin
          state_nxt = SARC_IDLE;
        end
        SARC_SAMPLE: begin
          if (conv_tick) begin
            ticks_nxt = 5'(ticks_r + 5'h01);
            if (ticks_r == SARC_SAMPLE_TICKS - 5'h01) begin
              state_nxt = SARC_DECIDE;
            end
          end
        end
        SARC_DECIDE: begin
          if (conv_tick) begin
            ticks_nxt = 5'(ticks_r + 5'h01);
            // keep or drop the trial bit, try the next one
            trial_nxt = (comp_above_in ? trial_r : (trial_r & ~bit_r)) | (bit_r >> 1);
            bit_nxt = bit_r >> 1;
            if (bit_r[0]) begin
              if (ctrl_r.cont) begin
                state_nxt = SARC_SAMPLE;
                ticks_nxt = 5'h00;
                bit_nxt = 8'h80;
                trial_nxt = 8'h80;
              end else begin
                state_nxt = SARC_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // sixteen ticks per conversion plus up to one tick of phase
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= SARC_IDLE;
      trial_r <= 8'h00;
      bit_r <= 8'h00;
      ticks_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      trial_r <= trial_nxt;
      bit_r <= bit_nxt;
      ticks_r <= ticks_nxt;
    end
  end

  // ---------------------------------------------------------------
  // result and completion flag / interrupt
  // ---------------------------------------------------------------
  // references give fixed codes; reserved codes just take the comparator
  wire [7:0] conv_word = (ctrl_r.chan == SARC_CHAN_REF_HIGH) ? SARC_REF_HIGH_CODE :
                         (ctrl_r.chan == SARC_CHAN_REF_LOW) ? SARC_REF_LOW_CODE : final_word;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_r <= SARC_RESULT_RESET;
    end else if (done) begin
      result_r <= conv_word;
    end
  end

  // set wins over clear when a completion meets the clearing access
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      complete_r <= 1'b0;
    end else if (done & ~ctrl_r.irq_en) begin
      complete_r <= 1'b1;
    end else if (rd_result | ctrl_r.irq_en) begin
      complete_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_r <= 1'b0;
    end else if (done & ctrl_r.irq_en) begin
      irq_r <= 1'b1;
    end else if (rd_result | wr_sc | ~ctrl_r.irq_en) begin
      irq_r <= 1'b0;
    end
  end

  assign conv_irq_out = irq_r;

  // ---------------------------------------------------------------
  // read data; flag reads zero while interrupts enabled
  // ---------------------------------------------------------------
  wire flag_view = complete_r & ~ctrl_r.irq_en;
  wire [31:0] sc_word = {24'h000000, flag_view, ctrl_r.irq_en, ctrl_r.cont, ctrl_r.chan};
  wire [31:0] clk_word = {24'h000000, ctrl_r.prescale, ctrl_r.clk_src, 4'h0};
  wire [31:0] rd_word = (ph_raddr == SARC_OFS_STATUS_CONTROL) ? sc_word :
                        (ph_raddr == SARC_OFS_RESULT) ? {24'h000000, result_r} :
                        (ph_raddr == SARC_OFS_CLOCK_CONFIG) ? clk_word : 32'h00000000;

  // only whole-word transfers reach this slave, so size is not decoded
  wire unused_ok = |hsize_in | ph_read_r;
  assign hrdata_out = rd_word;

  // ---------------------------------------------------------------
  // analog mux controls
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_chan
      assign analog_out.chan_onehot[g] = (ctrl_r.chan == 5'(g)) & running;
    end
  endgenerate
  assign analog_out.ref_high_sel = (ctrl_r.chan == SARC_CHAN_REF_HIGH);
  assign analog_out.ref_low_sel = (ctrl_r.chan == SARC_CHAN_REF_LOW);
  assign analog_out.power_down = powered_down | stop_mode_in;
  assign analog_out.trial = trial_r;

endmodule : sarc_ctrl

// File: design/sarc_pkg.sv
// sarc_pkg: constants, register map and carrier types for the converter control block
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
package sarc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] SARC_OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] SARC_OFS_RESULT = 4'h4;
  localparam logic [3:0] SARC_OFS_CLOCK_CONFIG = 4'h8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SARC_BIT_COMPLETE = 7;
  localparam int SARC_BIT_IRQ_EN = 6;
  localparam int SARC_BIT_CONT = 5;
  localparam int SARC_BIT_CLK_SRC = 4;
  localparam int SARC_PRE_LSB = 5;

  // ---------------------------------------------------------------
  // reset values and channel codes
  // ---------------------------------------------------------------
  localparam logic [4:0] SARC_CHAN_RESET = 5'h1F;
  localparam logic [4:0] SARC_CHAN_EXT_LAST = 5'h05;
  localparam logic [4:0] SARC_CHAN_REF_HIGH = 5'h1D;
  localparam logic [4:0] SARC_CHAN_REF_LOW = 5'h1E;
  localparam logic [4:0] SARC_CHAN_OFF = 5'h1F;
  localparam logic [2:0] SARC_PRE_RESET = 3'h0;
  localparam logic [7:0] SARC_RESULT_RESET = 8'h00;
  localparam logic [7:0] SARC_REF_HIGH_CODE = 8'hFF;
  localparam logic [7:0] SARC_REF_LOW_CODE = 8'h00;

  // ---------------------------------------------------------------
  // cycle counts: conversion length in converter clocks
  // ---------------------------------------------------------------
  localparam logic [4:0] SARC_SAMPLE_TICKS = 5'h08;
  localparam logic [4:0] SARC_CONV_TICKS = 5'h10;
  localparam logic [3:0] SARC_DIV_MAX = 4'hF;

  // control fields, shared between bus side and sequencer
  typedef struct packed {
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic clk_src;
    logic [2:0] prescale;
  } sarc_ctrl_t;

  // analog side: comparator trial value out, decision back
  typedef struct packed {
    logic [7:0] trial;
    logic [5:0] chan_onehot;
    logic ref_high_sel;
    logic ref_low_sel;
    logic power_down;
  } sarc_analog_t;

endpackage : sarc_pkg

// File: design/sarc_divider.sv
// sarc_divider: power-of-two tick generator for the converter clock
// assumes the source enable is a one-cycle pulse or held high
`timescale 1ns/1ps
module sarc_divider (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic src_tick_in,
  input wire logic [2:0] prescale_in,
  input wire logic run_in,
  output logic tick_out
);
  import sarc_pkg::*;

  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic [3:0] mask;
  logic wrap;

  // ---------------------------------------------------------------
  // divide ratio: codes with top bit set all mean sixteen
  // ---------------------------------------------------------------
  assign mask = prescale_in[2] ? SARC_DIV_MAX : 4'((5'h01 << prescale_in[1:0]) - 5'h01);
  assign wrap = ((count_r & mask) == mask);
  assign count_nxt = (!run_in) ? 4'h0 : (src_tick_in ? 4'(count_r + 4'h1) : count_r);

  // counter on source ticks, held clear while idle
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_r <= 4'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // one-cycle enable, the converter clock
  assign tick_out = run_in & src_tick_in & wrap;

endmodule : sarc_divider

// File: tb/sarc_ctrl_asserts.sv
// sarc_ctrl_asserts: port checker for the converter control block
// assumes one clock domain; bound to sarc_ctrl below
`timescale 1ns/1ps
module sarc_ctrl_asserts (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic osc_tick_in,
  input wire logic stop_mode_in,
  input wire logic comp_above_in,
  input wire sarc_pkg::sarc_analog_t analog_out,
  input wire logic conv_irq_out
);
  import sarc_pkg::*;
  logic wr_r;
  logic ien_r;
  logic [4:0] ch_r;
  // ------------------------------------------
  // control register mirror
  // ------------------------------------------
  wire ap = hsel_in && hready_in && htrans_in[1];
  wire rd_res = ap && !hwrite_in && haddr_in[3:0] == SARC_OFS_RESULT;
  wire wr_ctl = ap && hwrite_in && haddr_in[3:0] == SARC_OFS_STATUS_CONTROL;
  // mirror kept from the bus, so no internal node is needed
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_r <= 1'b0;
      ien_r <= 1'b0;
      ch_r <= SARC_CHAN_RESET;
    end else begin
      wr_r <= wr_ctl;
      if (wr_r) begin
        ien_r <= hwdata_in[SARC_BIT_IRQ_EN];
        ch_r <= hwdata_in[4:0];
      end
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  property p_irq_rd; rd_res |=> !conv_irq_out; endproperty
  property p_irq_wr; wr_r |=> !conv_irq_out; endproperty
  property p_irq_en; $rose(conv_irq_out) |-> ien_r; endproperty
  property p_pdown; ch_r == SARC_CHAN_OFF |-> ##[0:1] analog_out.power_down; endproperty
  property p_ref_hi;
    analog_out.ref_high_sel |-> ch_r == 5'h1D || $past(ch_r) == 5'h1D;
  endproperty
  property p_ref_lo;
    analog_out.ref_low_sel |-> ch_r == 5'h1E || $past(ch_r) == 5'h1E;
  endproperty
  property p_onehot;
    |analog_out.chan_onehot |-> analog_out.chan_onehot == (6'h01 << ch_r)
      || analog_out.chan_onehot == (6'h01 << $past(ch_r));
  endproperty
  property p_stop;
    stop_mode_in [*2] |-> analog_out.chan_onehot == 6'h00 && !$rose(conv_irq_out);
  endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq held after read");
  a_irq_wr: assert property (p_irq_wr) else $error("irq held after write");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_pdown: assert property (p_pdown) else $error("not powered down");
  a_ref_hi: assert property (p_ref_hi) else $error("upper ref wrong code");
  a_ref_lo: assert property (p_ref_lo) else $error("lower ref wrong code");
  a_onehot: assert property (p_onehot) else $error("channel mux wrong");
  a_stop: assert property (p_stop) else $error("active in stop");
  c_irq: cover property ($rose(conv_irq_out));
  c_ref: cover property (analog_out.ref_low_sel);
  c_stop: cover property (stop_mode_in && |analog_out.chan_onehot);
endmodule : sarc_ctrl_asserts

bind sarc_ctrl sarc_ctrl_asserts u_sarc_ctrl_asserts (.core_clk_in, .reset_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .osc_tick_in, .stop_mode_in, .comp_above_in, .analog_out,
  .conv_irq_out);

// File: tb/sarc_analog_model.sv
// sarc_analog_model: input levels and comparator of the analog side
// assumes a one-hot channel or a reference select while converting
`timescale 1ns/1ps
module sarc_analog_model (
  input wire logic core_clk_in,
  input wire sarc_pkg::sarc_analog_t analog_in,
  output logic comp_above_out
);
  import sarc_pkg::*;
  logic [7:0] vin;
  logic tog_r = 1'b0;
  wire sel = |analog_in.chan_onehot || analog_in.ref_high_sel || analog_in.ref_low_sel;
  // channel k sits at 8'h17 + 8'h29 * k; references at full and zero scale
  always_comb begin
    vin = analog_in.ref_high_sel ? 8'hFF : 8'h00;
    for (int k = 0; k < 6; k++) begin
      if (analog_in.chan_onehot[k]) begin
        vin = 8'h17 + 8'h29 * 8'(k);
      end
    end
  end
  // unselected input wanders so a stale decision cannot pass
  always @(posedge core_clk_in) begin
    tog_r <= !tog_r;
  end
  assign comp_above_out = sel ? vin >= analog_in.trial : tog_r;
endmodule : sarc_analog_model

// File: tb/tb_sarc_ctrl.sv
// tb_sarc_ctrl: self-checking bench for the converter control block
// assumes the bound checker and the analog model beside the design
`timescale 1ns/1ps
module tb_sarc_ctrl;
  import sarc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic stop = 1'b0;
  logic osc = 1'b0;
  logic [1:0] oc = 2'h0;
  logic [31:0] hrdata, rd;
  logic hrdy, hresp, comp, irq;
  sarc_analog_t ana;
  int fails = 0, tests_run = 0, n;
  logic [4:0] rch [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1E};
  logic [7:0] rex [8] = '{8'h17, 8'h40, 8'h69, 8'h92, 8'hBB, 8'hE4, 8'hFF, 8'h00};
  logic [7:0] pcf [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
  int pdv [7] = '{1, 2, 4, 8, 16, 16, 4};
  always #25 clk = ~clk;
  // oscillator enable: one pulse every fourth bus clock
  always @(posedge clk) begin
    oc <= oc + 2'h1;
    osc <= oc == 2'h3;
  end
  sarc_ctrl u_sarc_ctrl (.core_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .osc_tick_in(osc), .stop_mode_in(stop), .comp_above_in(comp), .analog_out(ana),
    .conv_irq_out(irq));
  sarc_analog_model u_sarc_analog_model (.core_clk_in(clk), .analog_in(ana),
    .comp_above_out(comp));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one single word transfer; read data taken at the falling edge inside the data phase
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {28'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    // sample before the closing edge so the edge's own updates cannot race in
    do begin
      @(negedge clk);
      rd = hrdata;
      @(posedge clk);
    end while (hrdy !== 1'b1);
  endtask : bus
  task automatic wait_flag();
    n = 0;
    do begin
      bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
      n++;
    end while (rd[7] !== 1'b1 && n < 200);
  endtask : wait_flag
  task automatic close_out();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  initial begin
    #1500000;
    fails++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, SARC_OFS_CLOCK_CONFIG, 8'h10);
    // first conversion after power-down only settles the analog side
    bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h00);
    wait_flag();
    bus(1'b0, SARC_OFS_RESULT, 8'h00);
    foreach (rch[i]) begin
      bus(1'b1, SARC_OFS_STATUS_CONTROL, {3'h0, rch[i]});
      wait_flag();
      bus(1'b0, SARC_OFS_RESULT, 8'h00);
      chk("result", {24'h0, rex[i]}, rd);
      bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
      chk("flag clear", {27'h0, rch[i]}, rd);
    end
    $display("channel rows done");
    foreach (pcf[i]) begin
      bus(1'b1, SARC_OFS_CLOCK_CONFIG, pcf[i]);
      bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h42);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      chk("span", 32'h1, {31'h0, n > 15 * pdv[i] && n <= 17 * pdv[i] + 3});
      bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
      chk("flag masked", 32'h42, rd);
      bus(1'b0, SARC_OFS_RESULT, 8'h00);
      chk("irq drop", 32'h0, {31'h0, irq});
    end
    $display("prescale rows done");
    bus(1'b1, SARC_OFS_CLOCK_CONFIG, 8'h10);
    bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h24);
    wait_flag();
    bus(1'b0, SARC_OFS_RESULT, 8'h00);
    chk("cont result", 32'hBB, rd);
    wait_flag();
    chk("cont again", 32'h1, {31'h0, rd[7]});
    bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h05);
    // flag left over from continuous mode; the control write keeps it
    bus(1'b0, SARC_OFS_RESULT, 8'h00);
    wait_flag();
    bus(1'b0, SARC_OFS_RESULT, 8'h00);
    chk("single result", 32'hE4, rd);
    repeat (60) @(posedge clk);
    bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
    chk("single once", 32'h05, rd);
    bus(1'b1, SARC_OFS_RESULT, 8'hAA);
    bus(1'b0, SARC_OFS_RESULT, 8'h00);
    chk("result ro", 32'hE4, rd);
    bus(1'b0, 4'hC, 8'h00);
    chk("unmapped", 32'h0, rd);
    $display("mode tests done");
    bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h01);
    stop <= 1'b1;
    repeat (80) @(posedge clk);
    bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
    chk("stop abort", 32'h01, rd);
    stop <= 1'b0;
    // irq enable and continuous set too, so the reset check below has work
    bus(1'b1, SARC_OFS_STATUS_CONTROL, 8'h7F);
    @(negedge clk);
    chk("power down", 32'h1, {31'h0, ana.power_down});
    $display("stop test done");
    // second reset: control bits and clock source back to defaults
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, SARC_OFS_STATUS_CONTROL, 8'h00);
    chk("status reset", 32'h1F, rd);
    bus(1'b0, SARC_OFS_CLOCK_CONFIG, 8'h00);
    chk("clock reset", 32'h0, rd);
    $display("reset test done");
    close_out();
  end
endmodule : tb_sarc_ctrl
